// ### pkg/bip_params.svh
// constants for the byte port with service-request handshake
`ifndef BIP_PARAMS_SVH
`define BIP_PARAMS_SVH
`define BIP_DATA_W 8
`define BIP_REG_RST 8'h00
`define BIP_MODE_IN 1'h0
`define BIP_MODE_OUT 1'h1
`define BIP_FLAG_RST 1'h1
`endif

// ### pkg/bip_pkg.sv
// types shared by the byte port modules
package bip_pkg;
  typedef enum logic [1:0] {
    BIP_ST_LOAD = 2'h1,
    BIP_ST_HOLD = 2'h2
  } bip_state_t;
endpackage : bip_pkg

// ### pkg/bip_ctl_if.sv
// interface between the port core and its request flip-flop
`timescale 1ns/1ps
interface bip_ctl_if;
  logic strobe_fall;
  logic deselect;
  logic mode;
  logic clear_n;
  logic flag;
  modport core (output strobe_fall, output deselect, output mode, output clear_n, input flag);
  modport flop (input strobe_fall, input deselect, input mode, input clear_n, output flag);
endinterface : bip_ctl_if

// ### hdl/bip_svc_flop.sv
// service request flip-flop: set by deselect and cleared by strobe fall in input mode, the reverse in output mode
`timescale 1ns/1ps
`include "bip_params.svh"
module bip_svc_flop (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  bip_ctl_if.flop ctl
);
  import bip_pkg::*;
  logic flag_r;
  logic flag_nxt;
  // deselect drives the pin to idle in input mode, to request in output mode
  // a passed strobe fall does the opposite; deselect wins when both coincide
  assign flag_nxt = ctl.deselect ? !ctl.mode : (ctl.strobe_fall ? ctl.mode : flag_r);
  // flag high means the raw output pin is high in input mode, low in output mode
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !ctl.clear_n) begin
      flag_r <= `BIP_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign ctl.flag = flag_r;
  // clear forces the flop to its reset level
  a_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !ctl.clear_n |=> flag_r == `BIP_FLAG_RST)
    else $error("flag not reset by clear");
  // a passed strobe fall moves the flop to its data-waiting level
  a_flag_fall: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ctl.clear_n && ctl.strobe_fall && !ctl.deselect |=> flag_r == $past(ctl.mode))
    else $error("strobe fall kept flag");
  // deselect moves the flop to its released level
  a_flag_desel: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ctl.clear_n && ctl.deselect |=> flag_r == !$past(ctl.mode))
    else $error("deselect missed flag");
  // with no event the flop keeps its level
  a_flag_keep: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ctl.clear_n && !ctl.deselect && !ctl.strobe_fall |=> $stable(flag_r))
    else $error("flag moved without event");
endmodule : bip_svc_flop

// ### hdl/bip_port.sv
// byte-wide latch port with handshake, sampled on the system clock
`timescale 1ns/1ps
`include "bip_params.svh"
module bip_port #(
  parameter int DATA_W = `BIP_DATA_W
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLEAR_N,
  input wire logic PORT_MODE,
  input wire logic STROBE,
  input wire logic SELECT_A,
  input wire logic SELECT_B,
  input wire logic [DATA_W-1:0] PORT_IN_BUS,
  output logic [DATA_W-1:0] PORT_OUT_BUS,
  output logic PORT_OUT_OE,
  output logic SVC_REQUEST_OUT,
  output bip_pkg::bip_state_t LATCH_STATE
);
  import bip_pkg::*;
  bip_ctl_if ctl ();
  logic [DATA_W-1:0] hold_r;
  logic [DATA_W-1:0] hold_nxt;
  logic strobe_d_r;
  bip_state_t state_r;
  bip_state_t state_nxt;
  wire logic mode_out;
  wire logic selected_in;
  wire logic write_qual;
  wire logic load_en;
  wire logic fall;
  wire logic fall_blocked;
  wire logic deselect;
  wire logic oe_nxt;
  logic oe_r;
  logic svc_r;

  ////////////////////////////////////////////////////////////////////////
  // mode and qualifier decode
  assign mode_out = (PORT_MODE == `BIP_MODE_OUT);
  assign selected_in = SELECT_A && SELECT_B;
  assign write_qual = !SELECT_A && SELECT_B;
  // transparent load while strobe high; output mode also needs the selects
  assign load_en = STROBE && (mode_out ? write_qual : 1'h1);
  // edge is found against the previous sample, so one clock of latency
  assign fall = strobe_d_r && !STROBE;
  assign deselect = mode_out ? (SELECT_A || !SELECT_B) : !selected_in;
  assign hold_nxt = load_en ? PORT_IN_BUS : hold_r;
  assign state_nxt = load_en ? BIP_ST_LOAD : BIP_ST_HOLD;
  assign oe_nxt = mode_out ? 1'h1 : selected_in;

  ////////////////////////////////////////////////////////////////////////
  // holding register; captured value is the last sample before strobe fall
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !CLEAR_N) begin
      hold_r <= DATA_W'(`BIP_REG_RST);
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // previous strobe sample; resets to the idle low level, so no false fall
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !CLEAR_N) begin
      strobe_d_r <= 1'h0;
    end else begin
      strobe_d_r <= STROBE;
    end
  end

  // load or hold marker, for observation only
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !CLEAR_N) begin
      state_r <= BIP_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request flip-flop lives in its own module
  // in output mode a strobe fall may lower the request only on a qualified write
  assign fall_blocked = mode_out && !write_qual;
  assign ctl.strobe_fall = fall && !fall_blocked;
  assign ctl.deselect = deselect;
  assign ctl.mode = mode_out;
  assign ctl.clear_n = CLEAR_N;

  bip_svc_flop u_flop (
    .SYS_CLK(SYS_CLK),
    .RESETN(RESETN),
    .ctl(ctl)
  );

  ////////////////////////////////////////////////////////////////////////
  // output stage registered; pin polarity follows mode
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      oe_r <= 1'h0;
      svc_r <= 1'h1;
    end else begin
      oe_r <= oe_nxt;
      svc_r <= mode_out ? !ctl.flag : ctl.flag;
    end
  end
  assign PORT_OUT_BUS = hold_r;
  assign PORT_OUT_OE = oe_r;
  assign SVC_REQUEST_OUT = svc_r;
  assign LATCH_STATE = state_r;

  ////////////////////////////////////////////////////////////////////////
  // checks on the holding register

  // in input mode the register follows the data while the strobe is high
  a_follow_strobe: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && STROBE && !mode_out |=> hold_r == $past(PORT_IN_BUS))
    else $error("no follow");

  // with the strobe low the register holds
  a_hold_low: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && !STROBE |=> $stable(hold_r))
    else $error("hold changed");

  // unqualified output-mode strobes leave the register alone
  a_out_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && mode_out && STROBE && !write_qual |=> $stable(hold_r))
    else $error("unqualified write");

  // qualified output-mode strobes load the data
  a_out_load: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && mode_out && STROBE && write_qual |=> hold_r == $past(PORT_IN_BUS))
    else $error("qualified write lost");

  // clear zeroes the register
  a_clear_reg: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !CLEAR_N |=> hold_r == `BIP_REG_RST)
    else $error("clear missed");

  // clear wins over a strobe that is high at the same time
  a_clear_strobe: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !CLEAR_N && STROBE |=> hold_r == `BIP_REG_RST)
    else $error("strobe beat clear");

  // system reset leaves outputs quiet and the register empty
  a_reset_out: assert property (@(posedge SYS_CLK)
    !RESETN |=> !PORT_OUT_OE && SVC_REQUEST_OUT && hold_r == `BIP_REG_RST)
    else $error("reset state wrong");

  ////////////////////////////////////////////////////////////////////////
  // checks on the load marker

  // marker is always one of the two one-hot codes
  a_state_known: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    state_r == BIP_ST_LOAD || state_r == BIP_ST_HOLD)
    else $error("marker code bad");

  // marker shows loading after a transparent cycle
  a_state_load: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && load_en |=> state_r == BIP_ST_LOAD)
    else $error("marker not loading");

  // marker shows holding once the strobe is gone
  a_state_hold: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && !load_en |=> state_r == BIP_ST_HOLD)
    else $error("marker not holding");

  // clear returns the marker to holding
  a_state_clear: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !CLEAR_N |=> state_r == BIP_ST_HOLD)
    else $error("marker kept on clear");

  ////////////////////////////////////////////////////////////////////////
  // checks on the output enable

  // input mode drives only while both selects are high
  a_oe_input: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !mode_out && $stable(PORT_MODE) |=> PORT_OUT_OE == $past(selected_in))
    else $error("bad oe");

  // input mode floats once either select drops
  a_in_float: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !mode_out && !selected_in && $stable(PORT_MODE) |=> !PORT_OUT_OE)
    else $error("input mode not floating");

  // output mode always drives
  a_oe_output: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    mode_out |=> PORT_OUT_OE)
    else $error("output mode not driving");

  ////////////////////////////////////////////////////////////////////////
  // checks on the service request pin, two stages after the cause

  // output mode raises the request when deselected
  a_desel_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && mode_out && deselect ##1 mode_out |=> SVC_REQUEST_OUT)
    else $error("no request");

  // input mode returns the pin high when deselected
  a_desel_in: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && !mode_out && deselect ##1 !mode_out |=> SVC_REQUEST_OUT)
    else $error("no release");

  // input mode strobe fall shows data waiting
  a_fall_in_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && !mode_out && ctl.strobe_fall && !deselect ##1 !mode_out |=> !SVC_REQUEST_OUT)
    else $error("input fall kept pin high");

  // output mode qualified fall lowers the request
  a_fall_out_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && mode_out && ctl.strobe_fall && !deselect ##1 mode_out |=> !SVC_REQUEST_OUT)
    else $error("output fall kept request");

  // clear in input mode leaves the pin high
  a_clear_in_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !CLEAR_N && !mode_out ##1 !mode_out |=> SVC_REQUEST_OUT)
    else $error("clear pin low in input mode");

  // clear in output mode leaves the pin low
  a_clear_out_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !CLEAR_N && mode_out ##1 mode_out |=> !SVC_REQUEST_OUT)
    else $error("clear pin high in output mode");

  // input mode pin keeps its level when nothing happens
  a_keep_in_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && !mode_out && !deselect && !ctl.strobe_fall ##1 !mode_out |=> $stable(SVC_REQUEST_OUT))
    else $error("input pin moved");

  // output mode request keeps its level when nothing happens
  a_keep_out_req: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    CLEAR_N && mode_out && !deselect && !ctl.strobe_fall ##1 mode_out |=> $stable(SVC_REQUEST_OUT))
    else $error("output request moved");
endmodule : bip_port

// ### sim/bip_periph_model.sv
// peripheral model that strobes one byte into the port
`timescale 1ns/1ps
module bip_periph_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic strobe,
  output logic [7:0] bus
);
  logic [1:0] cnt_r = 2'h0;
  initial strobe = 1'b0;
  initial bus = 8'h00;
  // two cycles high, data kept one past the fall, then released (inverted)
  always @(posedge clk) begin
    if (go && cnt_r == 2'h0) begin
      cnt_r <= 2'h3;
      strobe <= 1'b1;
      bus <= byte_in;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
      if (cnt_r == 2'h2) strobe <= 1'b0;
      if (cnt_r == 2'h1) bus <= ~bus;
    end
  end
endmodule : bip_periph_model

// ### sim/tb_top.sv
// self-checking bench for the byte port
`timescale 1ns/1ps
module tb_top;
  import bip_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clr_n = 1'b1;
  logic mode = 1'b0;
  logic sa = 1'b0;
  logic sb = 1'b0;
  logic go = 1'b0;
  logic [7:0] pb = 8'h00;
  logic stb;
  logic oe;
  logic svc;
  logic [7:0] ib;
  logic [7:0] ob;
  logic [7:0] d;
  logic [7:0] held;
  logic [1:0] st;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  bip_port u_bip_port (.SYS_CLK(clk), .RESETN(rstn), .CLEAR_N(clr_n), .PORT_MODE(mode), .STROBE(stb),
    .SELECT_A(sa), .SELECT_B(sb), .PORT_IN_BUS(ib), .PORT_OUT_BUS(ob), .PORT_OUT_OE(oe),
    .SVC_REQUEST_OUT(svc), .LATCH_STATE(st));
  bip_periph_model u_bip_periph_model (.clk(clk), .go(go), .byte_in(pb), .strobe(stb), .bus(ib));
  // output-mode writes only land with a low and b high
  function automatic logic [7:0] after_wr(logic a, logic b, logic [7:0] old, logic [7:0] nw);
    return (!a && b) ? nw : old;
  endfunction : after_wr
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one strobe from the peripheral; ld says whether the port should take it
  task automatic put(input logic [7:0] v, input logic ld);
    @(posedge clk);
    go <= 1'b1;
    pb <= v;
    @(posedge clk);
    go <= 1'b0;
    tick(1);
    chk({6'h0, st}, ld ? {6'h0, BIP_ST_LOAD} : {6'h0, BIP_ST_HOLD});
    if (ld) chk(ob, v);
    tick(5);
    chk({6'h0, st}, {6'h0, BIP_ST_HOLD});
  endtask : put
  task automatic sel(input logic a, input logic b);
    @(posedge clk);
    sa <= a;
    sb <= b;
    tick(3);
  endtask : sel
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // hang guard, well past the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    void'($urandom(89));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    chk(ob, 8'h00);
    chk({7'h0, svc}, 8'h01);
    chk({7'h0, oe}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      sel(1'b1, 1'b1);
      put(d, 1'b1);
      chk({7'h0, svc}, 8'h00);
      chk({7'h0, oe}, 8'h01);
      chk(ob, d);
      sel(i[0], ~i[0]);
      chk({7'h0, oe}, 8'h00);
      chk({7'h0, svc}, 8'h01);
    end
    @(posedge clk);
    mode <= 1'b1;
    clr_n <= 1'b0;
    tick(3);
    chk(ob, 8'h00);
    chk({7'h0, svc}, 8'h00);
    @(posedge clk);
    clr_n <= 1'b1;
    held = 8'h00;
    for (int i = 0; i < 4; i++) begin
      sel(i[0], i[1]);
      chk({7'h0, oe}, 8'h01);
      d = 8'($urandom);
      put(d, !i[0] && i[1]);
      held = after_wr(i[0], i[1], held, d);
      chk(ob, held);
      chk({7'h0, svc}, {7'h0, i != 2});
    end
    sel(1'b0, 1'b1);
    @(posedge clk);
    clr_n <= 1'b0;
    put(8'hA5, 1'b0);
    chk(ob, 8'h00);
    chk({7'h0, svc}, 8'h00);
    @(posedge clk);
    clr_n <= 1'b1;
    tick(2);
    end_sim();
  end
endmodule : tb_top
